// >>> hw/wuc_cfg.svh
// timing counts, register offsets, field positions and reset values
`ifndef WUC_CFG_SVH
`define WUC_CFG_SVH
`define WUC_CLK_MHZ 250
`define WUC_PULSE_MS 100
`define WUC_PULSE_CYC (`WUC_PULSE_MS * 1000 * `WUC_CLK_MHZ)
`define WUC_ERASE_S 8
`define WUC_ERASE_CYC (`WUC_ERASE_S * 1000000 * `WUC_CLK_MHZ)
`define WUC_PRESET_MAX 16'hEA60
`define WUC_OFF_CTRL 8'h00
`define WUC_OFF_CMD 8'h04
`define WUC_OFF_PRESET 8'h08
`define WUC_OFF_STATUS 8'h0C
`define WUC_OFF_COUNT 8'h10
`define WUC_OFF_IRQ 8'h14
`define WUC_OFF_MASK 8'h18
`define WUC_CTRL_REMOTE 0
`define WUC_CTRL_COUNT_ALL 1
`define WUC_CTRL_PULSED 2
`define WUC_CTRL_OFFLINE_PRESS 3
`define WUC_CTRL_OFFLINE 4
`define WUC_CTRL_RESET 32'h0000_0002
`define WUC_CMD_UP 0
`define WUC_CMD_DOWN 1
`define WUC_CMD_COPY 2
`define WUC_CMD_ERASE 3
`define WUC_CMD_ERASE_ALL 4
`define WUC_CMD_RESET_CNT 5
`define WUC_CMD_PRESET 6
`define WUC_CMD_YES 7
`define WUC_CMD_NO 8
`define WUC_IRQ_DONE 0
`define WUC_IRQ_PART 1
`define WUC_IRQ_REJECT 2
`endif

// >>> hw/wuc_pkg.sv
// types of the weld utility control block
package wuc_pkg;
    typedef enum logic [2:0] {
        WUC_IDLE = 3'b000,
        WUC_COPY_SRC = 3'b001,
        WUC_COPY_DST = 3'b010,
        WUC_COPY_CONF = 3'b011,
        WUC_ERASE_CONF = 3'b100,
        WUC_ALL_CONF = 3'b101,
        WUC_ALL_BUSY = 3'b110,
        WUC_RESET_CONF = 3'b111
    } wuc_state_e;
    typedef struct packed {
        logic bad_part;
        logic good_part;
        logic ready;
        logic in_dwell;
    } wuc_status_s;
    typedef struct packed {
        logic cycle_done;
        logic suspect;
        logic bad;
    } wuc_weld_s;
endpackage : wuc_pkg

// >>> hw/wuc_top.sv
// weld utility control: setups, part counter, status outputs, press gate
//
// The AXI4-Lite slave port and the address map are this design's own decisions.
`timescale 1ns/1ps
`include "wuc_cfg.svh"
module wuc_top #(
    parameter int unsigned PULSE_CYC = `WUC_PULSE_CYC,
    parameter int unsigned ERASE_CYC = `WUC_ERASE_CYC
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [4:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [4:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic [2:0] remote_setup_bits,
    input wire logic palm_left,
    input wire logic palm_right,
    input wire logic auto_trigger,
    input wire logic [2:0] weld_in,
    input wire logic [3:0] status_in,
    output logic [3:0] iso_status,
    output logic press_cycle,
    output logic ultrasonic_enable,
    output logic weld_terminate,
    output logic [2:0] setup_identifier,
    output logic setup_copy,
    output logic setup_erase,
    output logic setup_erase_all,
    output logic [2:0] copy_source,
    output logic irq
);
////////////////////////////////////////////////////////////////////////////
    // write address is five bits so every register up to mask is reachable
    logic [4:0] awaddr;
    assign awaddr = s_axi_awaddr;

    // two-flop synchronisers for every pin input
    logic [16:0] sync1, sync2;
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            sync1 <= 17'h0_0000;
            sync2 <= 17'h0_0000;
        end else begin
            sync1 <= {remote_setup_bits, palm_left, palm_right, auto_trigger,
                      weld_in, status_in, 4'h0};
            sync2 <= sync1;
        end
    end
    logic [2:0] remote_s;
    logic palms_s, trig_s;
    wuc_pkg::wuc_weld_s weld_s;
    wuc_pkg::wuc_status_s stat_s;
    assign remote_s = sync2[16:14];
    assign palms_s = sync2[13] & sync2[12];
    assign trig_s = sync2[11];
    assign weld_s = sync2[10:8];
    assign stat_s = sync2[7:4];

////////////////////////////////////////////////////////////////////////////
    // bus handshake and registers
    logic aw_hold, w_hold, ar_hold;
    logic [4:0] aw_q;
    logic [31:0] w_q;
    logic [31:0] ctrl, preset, mask;
    logic [2:0] irq_st;
    logic [31:0] cmd_pulse;
    logic do_write;
    assign do_write = aw_hold & w_hold & ~s_axi_bvalid;

    function automatic logic hit(input logic [4:0] a, input logic [7:0] off);
        hit = ({3'b000, a} == off);
    endfunction : hit

    logic [31:0] next_ctrl, next_preset, next_mask, next_rdata;
    logic [2:0] clr_irq;
    always_comb begin
        next_ctrl = ctrl;
        next_preset = preset;
        next_mask = mask;
        cmd_pulse = 32'h0000_0000;
        clr_irq = 3'b000;
        if (do_write) begin
            if (hit(aw_q, `WUC_OFF_CTRL)) next_ctrl = w_q;
            if (hit(aw_q, `WUC_OFF_CMD)) cmd_pulse = w_q;
            if (hit(aw_q, `WUC_OFF_PRESET)) next_preset = w_q;
            if (hit(aw_q, `WUC_OFF_IRQ)) clr_irq = w_q[2:0];
            if (hit(aw_q, `WUC_OFF_MASK)) next_mask = w_q;
        end
    end

    // read multiplexer
    wuc_pkg::wuc_state_e state;
    logic [15:0] count;
    always_comb begin
        next_rdata = 32'h0000_0000;
        if (hit(s_axi_araddr, `WUC_OFF_CTRL)) next_rdata = {27'h0, ctrl[4:0]};
        else if (hit(s_axi_araddr, `WUC_OFF_PRESET))
            next_rdata = {16'h0000, preset[15:0]};
        else if (hit(s_axi_araddr, `WUC_OFF_STATUS))
            next_rdata = {25'h0, state, copy_source, setup_identifier[0]};
        else if (hit(s_axi_araddr, `WUC_OFF_COUNT))
            next_rdata = {16'h0000, count};
        else if (hit(s_axi_araddr, `WUC_OFF_IRQ))
            next_rdata = {29'h0, irq_st};
        else if (hit(s_axi_araddr, `WUC_OFF_MASK))
            next_rdata = {29'h0, mask[2:0]};
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_hold <= 1'b0;
            w_hold <= 1'b0;
            aw_q <= 5'h00;
            w_q <= 32'h0000_0000;
            s_axi_bvalid <= 1'b0;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0000_0000;
            ctrl <= `WUC_CTRL_RESET;
            preset <= 32'h0000_0000;
            mask <= 32'h0000_0000;
        end else begin
            if (s_axi_awvalid & s_axi_awready) begin
                aw_hold <= 1'b1;
                aw_q <= awaddr;
            end
            if (s_axi_wvalid & s_axi_wready) begin
                w_hold <= 1'b1;
                w_q <= s_axi_wdata;
            end
            if (do_write) begin
                aw_hold <= 1'b0;
                w_hold <= 1'b0;
                s_axi_bvalid <= 1'b1;
            end else if (s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
            if (s_axi_arvalid & s_axi_arready) begin
                s_axi_rvalid <= 1'b1;
                s_axi_rdata <= next_rdata;
            end else if (s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
            ctrl <= next_ctrl;
            mask <= next_mask;
            if (next_preset <= {16'h0000, `WUC_PRESET_MAX})
                preset <= next_preset;
        end
    end
    assign s_axi_awready = ~aw_hold;
    assign s_axi_wready = ~w_hold;
    assign s_axi_arready = ~s_axi_rvalid;
    assign s_axi_bresp = 2'b00;
    assign s_axi_rresp = 2'b00;

////////////////////////////////////////////////////////////////////////////
    // setup storage sequencer
    logic [2:0] local_id, dst, next_local_id, next_dst, next_src;
    logic [31:0] erase_cnt, next_erase_cnt;
    wuc_pkg::wuc_state_e next_state;
    logic next_copy, next_erase, next_all, next_rst_cnt, done_ev;
    logic yes, no;
    assign yes = cmd_pulse[`WUC_CMD_YES];
    assign no = cmd_pulse[`WUC_CMD_NO];
    always_comb begin
        next_state = state;
        next_local_id = local_id;
        next_dst = dst;
        next_src = copy_source;
        next_erase_cnt = erase_cnt;
        next_copy = 1'b0;
        next_erase = 1'b0;
        next_all = 1'b0;
        next_rst_cnt = 1'b0;
        done_ev = 1'b0;
        case (state)
            wuc_pkg::WUC_IDLE: begin
                if (cmd_pulse[`WUC_CMD_UP])
                    next_local_id = local_id + 3'd1;
                else if (cmd_pulse[`WUC_CMD_DOWN])
                    next_local_id = local_id - 3'd1;
                if (cmd_pulse[`WUC_CMD_COPY])
                    next_state = wuc_pkg::WUC_COPY_SRC;
                else if (cmd_pulse[`WUC_CMD_ERASE])
                    next_state = wuc_pkg::WUC_ERASE_CONF;
                else if (cmd_pulse[`WUC_CMD_ERASE_ALL])
                    next_state = wuc_pkg::WUC_ALL_CONF;
                else if (cmd_pulse[`WUC_CMD_RESET_CNT])
                    next_state = wuc_pkg::WUC_RESET_CONF;
            end
            wuc_pkg::WUC_COPY_SRC: begin
                // up/down steps the source, yes accepts it
                if (cmd_pulse[`WUC_CMD_UP]) next_src = copy_source + 3'd1;
                if (cmd_pulse[`WUC_CMD_DOWN]) next_src = copy_source - 3'd1;
                if (yes) next_state = wuc_pkg::WUC_COPY_DST;
                if (no) next_state = wuc_pkg::WUC_IDLE;
            end
            wuc_pkg::WUC_COPY_DST: begin
                if (cmd_pulse[`WUC_CMD_UP]) next_dst = dst + 3'd1;
                if (cmd_pulse[`WUC_CMD_DOWN]) next_dst = dst - 3'd1;
                if (yes) next_state = wuc_pkg::WUC_COPY_CONF;
                if (no) next_state = wuc_pkg::WUC_IDLE;
            end
            wuc_pkg::WUC_COPY_CONF: begin
                if (yes) begin
                    next_copy = 1'b1;
                    done_ev = 1'b1;
                end
                if (yes | no) next_state = wuc_pkg::WUC_IDLE;
            end
            wuc_pkg::WUC_ERASE_CONF: begin
                if (yes) begin
                    next_erase = 1'b1;
                    done_ev = 1'b1;
                end
                if (yes | no) next_state = wuc_pkg::WUC_IDLE;
            end
            wuc_pkg::WUC_ALL_CONF: begin
                if (yes) begin
                    next_all = 1'b1;
                    next_erase_cnt = ERASE_CYC - 1;
                    next_state = wuc_pkg::WUC_ALL_BUSY;
                end else if (no) next_state = wuc_pkg::WUC_IDLE;
            end
            wuc_pkg::WUC_ALL_BUSY: begin
                next_all = 1'b1;
                next_erase_cnt = erase_cnt - 32'd1;
                if (erase_cnt == 32'd0) begin
                    next_all = 1'b0;
                    done_ev = 1'b1;
                    next_state = wuc_pkg::WUC_IDLE;
                end
            end
            wuc_pkg::WUC_RESET_CONF: begin
                if (yes) next_rst_cnt = 1'b1;
                if (yes | no) next_state = wuc_pkg::WUC_IDLE;
            end
            default: next_state = wuc_pkg::WUC_IDLE;
        endcase
    end

    // active setup: remote bits override local choice
    logic [2:0] next_id;
    assign next_id = ctrl[`WUC_CTRL_REMOTE] ? remote_s : next_local_id;
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            state <= wuc_pkg::WUC_IDLE;
            local_id <= 3'd0;
            dst <= 3'd0;
            copy_source <= 3'd0;
            erase_cnt <= 32'd0;
            setup_identifier <= 3'd0;
            setup_copy <= 1'b0;
            setup_erase <= 1'b0;
            setup_erase_all <= 1'b0;
        end else begin
            state <= next_state;
            local_id <= next_local_id;
            dst <= next_dst;
            copy_source <= next_src;
            erase_cnt <= next_erase_cnt;
            setup_identifier <= next_copy ? dst : next_id;
            setup_copy <= next_copy;
            setup_erase <= next_erase;
            setup_erase_all <= next_all;
        end
    end

////////////////////////////////////////////////////////////////////////////
    // part counter and weld qualification
    logic [15:0] next_count;
    logic qualify, part_ev, reject_ev;
    assign part_ev = weld_s.cycle_done;
    assign reject_ev = weld_s.suspect | weld_s.bad;
    assign qualify = part_ev &
                     (ctrl[`WUC_CTRL_COUNT_ALL] | ~reject_ev);
    always_comb begin
        next_count = count;
        if (next_rst_cnt) next_count = 16'h0000;
        else if (cmd_pulse[`WUC_CMD_PRESET]) next_count = preset[15:0];
        else if (qualify) next_count = count + 16'd1;
    end
    always_ff @(posedge aclk) begin
        if (!aresetn) count <= 16'h0000;
        else count <= next_count;
    end

////////////////////////////////////////////////////////////////////////////
    // isolated status outputs, one stretcher per line
    logic [3:0] prev_stat, next_iso;
    logic [31:0] pcnt [4];
    logic [31:0] next_pcnt [4];
    generate
        for (genvar i = 0; i < 4; i++) begin : g_out
            always_comb begin
                next_pcnt[i] = pcnt[i];
                if (!ctrl[`WUC_CTRL_PULSED]) begin
                    next_iso[i] = stat_s[i];
                    next_pcnt[i] = 32'd0;
                end else if (stat_s[i] & ~prev_stat[i]) begin
                    next_iso[i] = 1'b1;
                    next_pcnt[i] = PULSE_CYC - 1;
                end else if (pcnt[i] != 32'd0) begin
                    next_iso[i] = 1'b1;
                    next_pcnt[i] = pcnt[i] - 32'd1;
                end else begin
                    next_iso[i] = 1'b0;
                end
            end
            always_ff @(posedge aclk) begin
                if (!aresetn) pcnt[i] <= 32'd0;
                else pcnt[i] <= next_pcnt[i];
            end
        end
    endgenerate
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            prev_stat <= 4'h0;
            iso_status <= 4'h0;
        end else begin
            prev_stat <= stat_s;
            iso_status <= next_iso;
        end
    end

////////////////////////////////////////////////////////////////////////////
    // press gating and weld termination
    logic offline, opt, next_press, next_us;
    assign offline = ctrl[`WUC_CTRL_OFFLINE];
    assign opt = ctrl[`WUC_CTRL_OFFLINE_PRESS];
    always_comb begin
        if (!offline) begin
            next_press = palms_s | trig_s;
            next_us = palms_s | trig_s;
        end else begin
            next_press = opt & palms_s;
            next_us = 1'b0;
        end
    end

    // interrupt status: set wins over clear
    logic [2:0] ev, next_irq;
    assign ev = {reject_ev & part_ev, qualify, done_ev};
    assign next_irq = (irq_st & ~clr_irq) | ev;
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            press_cycle <= 1'b0;
            ultrasonic_enable <= 1'b0;
            weld_terminate <= 1'b0;
            irq_st <= 3'b000;
            irq <= 1'b0;
        end else begin
            press_cycle <= next_press;
            ultrasonic_enable <= next_us;
            weld_terminate <= weld_s.bad;
            irq_st <= next_irq;
            irq <= |(next_irq & mask[2:0]);
        end
    end
endmodule : wuc_top

// >>> verif/wuc_checker.sv
// concurrent checks on the weld utility control ports
`timescale 1ns/1ps
module wuc_checker #(
    parameter int unsigned PULSE_CYC = 10,
    parameter int unsigned ERASE_CYC = 20
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [4:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic palm_left,
    input wire logic palm_right,
    input wire logic [2:0] weld_in,
    input wire logic [3:0] status_in,
    input wire logic [3:0] iso_status,
    input wire logic press_cycle,
    input wire logic ultrasonic_enable,
    input wire logic weld_terminate,
    input wire logic setup_erase_all
);
    logic [4:0] aw_a;
    logic [31:0] w_d;
    logic [4:0] ctl;
    logic [2:0] stb_n;
    logic [3:0] palm_h;
    logic [31:0] pcnt;
    logic [31:0] ecnt;
    wire logic bdone = s_axi_bvalid && s_axi_bready;
    wire logic awc = s_axi_awvalid && s_axi_awready && s_axi_awaddr == 5'h00;
    wire logic stb = (stb_n == 3'h7);
    ////////////////////////////////////////////////////////////////////////
    // shadow control word, its stability window, palm history and width counters
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_a <= 5'h00;
            w_d <= 32'h0000_0000;
            ctl <= 5'h02;
            stb_n <= 3'h0;
            palm_h <= 4'h0;
            pcnt <= 32'h0000_0000;
            ecnt <= 32'h0000_0000;
        end else begin
            if (s_axi_awvalid && s_axi_awready) aw_a <= s_axi_awaddr;
            if (s_axi_wvalid && s_axi_wready) w_d <= s_axi_wdata;
            if (bdone && aw_a == 5'h00) ctl <= w_d[4:0];
            stb_n <= (awc || (bdone && aw_a == 5'h00)) ? 3'h0 :
                stb ? stb_n : stb_n + 3'h1;
            palm_h <= {palm_h[2:0], palm_left && palm_right};
            pcnt <= iso_status[3] ? pcnt + 32'h0000_0001 : 32'h0000_0000;
            ecnt <= setup_erase_all ? ecnt + 32'h0000_0001 : 32'h0000_0000;
        end
    end
    ////////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    sequence s_offl;
        ctl[4] && stb;
    endsequence
    sequence s_offl_opt;
        ctl[4] && ctl[3] && stb;
    endsequence
    property p_offl_block;
        s_offl |-> ctl[3] || !press_cycle;
    endproperty
    a_offl_block: assert property (p_offl_block) else $error("press off line");
    property p_no_trigger;
        s_offl_opt ##0 palm_h == 4'h0 |-> !press_cycle;
    endproperty
    a_no_trigger: assert property (p_no_trigger) else $error("press no palms");
    property p_palm_press;
        s_offl_opt ##0 palm_h == 4'hF |-> press_cycle;
    endproperty
    a_palm_press: assert property (p_palm_press) else $error("palms no press");
    property p_no_ultra;
        s_offl_opt |-> !ultrasonic_enable;
    endproperty
    a_no_ultra: assert property (p_no_ultra) else $error("ultrasound off line");
    property p_term;
        weld_terminate == $past(weld_in[0], 3);
    endproperty
    a_term: assert property (p_term) else $error("terminate not bad");
    property p_level;
        !ctl[2] && stb |-> iso_status == $past(status_in, 3);
    endproperty
    a_level: assert property (p_level) else $error("status not level");
    property p_pulse;
        ctl[2] && stb && $fell(iso_status[3]) |-> pcnt == PULSE_CYC;
    endproperty
    a_pulse: assert property (p_pulse) else $error("pulse width");
    property p_busy;
        $fell(setup_erase_all) |-> ecnt == ERASE_CYC;
    endproperty
    a_busy: assert property (p_busy) else $error("erase busy length");
endmodule : wuc_checker
bind wuc_top wuc_checker #(.PULSE_CYC(PULSE_CYC), .ERASE_CYC(ERASE_CYC))
    i_chk (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(s_axi_awaddr),
    .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_wdata(s_axi_wdata), .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready), .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready), .palm_left(palm_left),
    .palm_right(palm_right), .weld_in(weld_in), .status_in(status_in),
    .iso_status(iso_status), .press_cycle(press_cycle),
    .ultrasonic_enable(ultrasonic_enable), .weld_terminate(weld_terminate),
    .setup_erase_all(setup_erase_all));

// >>> verif/wuc_far_model.sv
// far side model: controller, front panel and press switches
`timescale 1ns/1ps
module wuc_far_model (
    input wire logic aclk,
    output logic [2:0] remote_setup_bits,
    output logic palm_left,
    output logic palm_right,
    output logic auto_trigger,
    output wuc_pkg::wuc_weld_s weld_in,
    output wuc_pkg::wuc_status_s status_in
);
    // idle levels from time zero
    initial begin
        remote_setup_bits = 3'h0;
        palm_left = 1'b0;
        palm_right = 1'b0;
        auto_trigger = 1'b0;
        weld_in = 3'h0;
        status_in = 4'h0;
    end
    // remote setup identifier bits
    task automatic sel(input logic [2:0] v);
        @(posedge aclk);
        remote_setup_bits <= v;
    endtask : sel
    // both palm switches move together
    task automatic palms(input logic v);
        @(posedge aclk);
        palm_left <= v;
        palm_right <= v;
    endtask : palms
    task automatic trig(input logic v);
        @(posedge aclk);
        auto_trigger <= v;
    endtask : trig
    task automatic stat(input logic [3:0] v);
        @(posedge aclk);
        status_in <= v;
    endtask : stat
    // one finished part: done pulse carrying its judgement
    task automatic part(input logic sus, input logic bad);
        @(posedge aclk);
        weld_in <= {1'b1, sus, bad};
        @(posedge aclk);
        weld_in <= 3'h0;
    endtask : part
endmodule : wuc_far_model

// >>> verif/tb.sv
// self-checking bench for the weld utility control block
`timescale 1ns/1ps
module tb;
    localparam int unsigned PC = 8;
    localparam int unsigned EC = 20;
    logic aclk = 1'b0;
    logic aresetn = 1'b0;
    logic [4:0] awaddr = 5'h00;
    logic [31:0] wdata = 32'h0000_0000;
    logic [4:0] araddr = 5'h00;
    logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
    logic arvalid = 1'b0, rready = 1'b0;
    logic awready, wready, bvalid, arready, rvalid;
    logic [1:0] bresp, rresp;
    logic [31:0] rdata, d;
    logic [2:0] rbits, sid, csrc;
    logic pl, pr, at, press, ultra, term, cpy, ers, ersa, irql;
    wuc_pkg::wuc_weld_s weld;
    wuc_pkg::wuc_status_s stin;
    logic [3:0] iso;
    int mismatches = 0, check_count = 0, cyc = 0;
    int copies = 0, erases = 0, busy = 0, terms = 0, pw = 0;
    always #2 aclk = ~aclk;
    wuc_top #(.PULSE_CYC(PC), .ERASE_CYC(EC)) i_dut (
        .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
        .s_axi_awvalid(awvalid), .s_axi_awready(awready),
        .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid),
        .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
        .s_axi_bready(bready), .s_axi_araddr(araddr),
        .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
        .s_axi_rready(rready), .remote_setup_bits(rbits), .palm_left(pl),
        .palm_right(pr), .auto_trigger(at), .weld_in(weld),
        .status_in(stin), .iso_status(iso), .press_cycle(press),
        .ultrasonic_enable(ultra), .weld_terminate(term),
        .setup_identifier(sid), .setup_copy(cpy), .setup_erase(ers),
        .setup_erase_all(ersa), .copy_source(csrc), .irq(irql));
    wuc_far_model i_plc (.aclk(aclk), .remote_setup_bits(rbits),
        .palm_left(pl), .palm_right(pr), .auto_trigger(at),
        .weld_in(weld), .status_in(stin));
    ////////////////////////////////////////////////////////////////////////
    // pulse counters and the hang watchdog
    always @(posedge aclk) begin
        cyc++;
        if (cpy === 1'b1) copies++;
        if (ers === 1'b1) erases++;
        if (ersa === 1'b1) busy++;
        if (term === 1'b1) terms++;
        if (iso[3] === 1'b1) pw++;
        if (cyc == 6000) begin
            mismatches++;
            print_verdict();
        end
    end
    task automatic print_verdict();
        $display("checks %0d mismatches %0d", check_count, mismatches);
        if (mismatches == 0 && check_count > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask : print_verdict
    task automatic chk(input string nm, input logic [31:0] s, e);
        check_count++;
        if (s !== e) begin
            mismatches++;
            $display("[ERR] %s expected %h seen %h", nm, e, s);
        end
    endtask : chk
    task automatic idle(input int n);
        repeat (n) @(posedge aclk);
    endtask : idle
    // register write: address and data offered together, each held till taken
    task automatic wr(input logic [4:0] a, input logic [31:0] v);
        @(posedge aclk);
        awaddr <= a;
        wdata <= v;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do begin
            @(posedge aclk);
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
        end while (!bvalid);
        bready <= 1'b0;
    endtask : wr
    task automatic cmd(input int b);
        wr(5'h04, 32'h0000_0001 << b);
    endtask : cmd
    task automatic rd(input logic [4:0] a);
        @(posedge aclk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do begin
            @(posedge aclk);
            if (arready) arvalid <= 1'b0;
        end while (!rvalid);
        d = rdata;
        rready <= 1'b0;
    endtask : rd
    task automatic cnt(input string nm, input logic [31:0] e);
        idle(6);
        rd(5'h10);
        chk(nm, d, e);
    endtask : cnt
    ////////////////////////////////////////////////////////////////////////
    // main sequence
    initial begin
        idle(10);
        aresetn <= 1'b1;
        rd(5'h00);
        chk("ctrl", d, 32'h0000_0002);
        rd(5'h1C);
        chk("unmapped", d, 32'h0000_0000);
        cnt("count", 32'h0000_0000);
        $display("reset test done");
        for (int m = 0; m < 2; m++) begin
            i_plc.part(1'b0, 1'b0);
            i_plc.part(1'b1, 1'b0);
            i_plc.part(1'b0, 1'b1);
            cnt("count", m ? 32'h0000_0004 : 32'h0000_0003);
            wr(5'h00, 32'h0000_0000);
        end
        chk("terminate", terms, 32'h0000_0002);
        rd(5'h14);
        chk("irq part", d[1], 32'h0000_0001);
        wr(5'h18, 32'h0000_0002);
        idle(2);
        chk("irq line", irql, 32'h0000_0001);
        wr(5'h14, 32'h0000_0007);
        idle(2);
        chk("irq cleared", irql, 32'h0000_0000);
        cmd(5);
        cnt("count held", 32'h0000_0004);
        cmd(7);
        cnt("count reset", 32'h0000_0000);
        wr(5'h08, 32'h0000_EA60);
        cmd(6);
        cnt("preset max", 32'h0000_EA60);
        wr(5'h08, 32'h0000_EA61);
        rd(5'h08);
        chk("preset over", d, 32'h0000_EA60);
        $display("counter test done");
        for (int i = 0; i < 4; i++) begin
            i_plc.stat(4'h1 << i);
            idle(5);
            chk("iso", iso, 32'h0000_0001 << i);
        end
        i_plc.stat(4'h0);
        wr(5'h00, 32'h0000_0006);
        idle(8);
        pw = 0;
        i_plc.stat(4'h8);
        idle(30);
        chk("pulse width", pw, PC);
        i_plc.stat(4'h0);
        $display("status test done");
        wr(5'h00, 32'h0000_0012);
        i_plc.palms(1'b1);
        idle(6);
        chk("press off line", press, 32'h0000_0000);
        i_plc.palms(1'b0);
        wr(5'h00, 32'h0000_001A);
        i_plc.trig(1'b1);
        idle(6);
        chk("press trigger", press, 32'h0000_0000);
        i_plc.trig(1'b0);
        i_plc.palms(1'b1);
        idle(6);
        chk("press palms", press, 32'h0000_0001);
        chk("ultrasound", ultra, 32'h0000_0000);
        i_plc.palms(1'b0);
        wr(5'h00, 32'h0000_0002);
        $display("press test done");
        repeat (7) cmd(0);
        idle(4);
        chk("setup up", sid, 32'h0000_0007);
        cmd(1);
        idle(4);
        chk("setup down", sid, 32'h0000_0006);
        wr(5'h00, 32'h0000_0003);
        i_plc.sel(3'h5);
        idle(6);
        chk("remote", sid, 32'h0000_0005);
        wr(5'h00, 32'h0000_0002);
        cmd(2);
        cmd(0);
        cmd(7);
        cmd(0);
        cmd(7);
        idle(4);
        chk("copy early", copies, 32'h0000_0000);
        cmd(7);
        idle(4);
        chk("copy", copies, 32'h0000_0001);
        chk("copy source", csrc, 32'h0000_0001);
        cmd(3);
        cmd(8);
        idle(4);
        chk("erase no", erases, 32'h0000_0000);
        cmd(3);
        cmd(7);
        idle(4);
        chk("erase yes", erases, 32'h0000_0001);
        cmd(4);
        cmd(7);
        idle(EC + 10);
        chk("erase all busy", busy, EC);
        $display("setup test done");
        print_verdict();
    end
endmodule : tb
